// ---- verilog/fes_pkg.sv ----
`default_nettype none
// Shared constants of the erase and suspend sequencer
package fes_pkg;
  // Flash-side widths and address fields
  localparam int A_W = 16;
  localparam int S_W = 4;
  localparam int D_W = 8;
  localparam int SEC_LSB = 12;
  localparam int BANK_BIT = 15;
  // Unlock cycle addresses (low twelve bits)
  localparam logic [11:0] UNL_A1 = 12'h555;
  localparam logic [11:0] UNL_A2 = 12'h2AA;
  // Command codes on the data bus
  localparam logic [7:0] C_UNL1 = 8'hAA;
  localparam logic [7:0] C_UNL2 = 8'h55;
  localparam logic [7:0] C_SETUP = 8'h80;
  localparam logic [7:0] C_ERS = 8'h30;
  localparam logic [7:0] C_RES = 8'h30;
  localparam logic [7:0] C_SUSP = 8'hB0;
  localparam logic [7:0] C_PGM = 8'hA0;
  localparam logic [7:0] C_BYP = 8'h20;
  localparam logic [7:0] C_ASEL = 8'h90;
  localparam logic [7:0] C_EXIT = 8'hF0;
  localparam logic [7:0] C_BYX = 8'h00;
  // Readout codes, arbitrary values
  localparam logic [7:0] MFG_ID = 8'h5A;
  localparam logic [7:0] DEV_ID = 8'hC3;
  // Status bit positions
  localparam int POLL_BIT = 7;
  localparam int TGL_BIT = 6;
  localparam int WIN_BIT = 3;
  localparam int STGL_BIT = 2;
  // Acceptance window timing
  localparam int WIN_NS = 50000;
  localparam int CLK_NS = 10;
  localparam int WIN_CYC = (WIN_NS + CLK_NS - 1) / CLK_NS;
  // Register map and reset values
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0040_0100;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Sequencer states, one-hot
  typedef enum logic [12:0] {
    S_IDLE = 13'h0001,
    S_CY1 = 13'h0002,
    S_CY2 = 13'h0004,
    S_SETUP = 13'h0008,
    S_CY4 = 13'h0010,
    S_CY5 = 13'h0020,
    S_WIN = 13'h0040,
    S_PREP = 13'h0080,
    S_ERASE = 13'h0100,
    S_PSET = 13'h0200,
    S_PROG = 13'h0400,
    S_ASEL = 13'h0800,
    S_BYX = 13'h1000
  } fes_state_t;
endpackage
`default_nettype wire

// ---- verilog/fes_sequencer.sv ----
// How it works
// - Erase takes six writes, four in bypass
// - Preprogram to zero before electrical erase
// - Window lasts at least fifty microseconds
// - Window timed from final strobe rising edge
// - Extra sectors queue; each restarts window
// - Other write in window returns read mode
// - Window state readable on status bit three
// - Erase done: array reads, addresses released
// - Erasing bank reads status, others array
// - Running erase honours only suspend
// - Hardware reset aborts erase immediately
// - Suspend needs bank; only during sector erase
// - Suspend within twenty microseconds, window ends
// - Suspended sectors read status on byte
// - Program in suspend returns to suspend-read
// - Readout sequence accepted in suspend-read
// - Resume with bank; repeats ignored
// - Program suspend halts program quickly
// - Program suspend allowed inside erase suspend
// - Readout allowed in program suspend, returns
// - Program resume any address, repeats ignored
// - Bypass entered by unlock pair plus code
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fes_sequencer #(
  parameter int WIN_CYC = fes_pkg::WIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Flash write cycle
  input wire logic weN,
  input wire logic [fes_pkg::A_W-1:0] wAddr,
  input wire logic [fes_pkg::D_W-1:0] wData,
  // Flash read cycle
  input wire logic rdEn,
  input wire logic [fes_pkg::A_W-1:0] rdAddr,
  input wire logic [fes_pkg::D_W-1:0] arrayData,
  output logic [fes_pkg::D_W-1:0] rdData,
  // Array control
  output logic preprogOn,
  output logic eraseOn,
  output logic progOn,
  output logic [(1<<fes_pkg::S_W)-1:0] sectorMask,
  output logic [fes_pkg::A_W-1:0] progAddr,
  output logic [fes_pkg::D_W-1:0] progData,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  fes_pkg::fes_state_t st; // Sequencer state
  logic weNq; // Strobe seen last cycle
  logic wr; // Rising strobe edge: one write
  logic eSusp; // Erase is suspended
  logic pSusp; // Program is suspended
  logic bypass; // Unlock bypass mode
  logic ersPhase; // Suspended erase was past preprogram
  logic ersBank; // Bank holding the erase
  logic [15:0] tmr; // Window and erase phase timer
  logic [15:0] prgTmr; // Program timer
  logic [31:0] ctrl; // Erase length low, program length high
  logic tgl; // Toggle status bit
  logic sTgl; // Sector toggle status bit
  logic [fes_pkg::D_W-1:0] next_rdData;
  logic [(1<<fes_pkg::S_W)-1:0] wSecBit; // Sector of the write
  logic wBank; // Bank of the write
  logic rBank; // Bank of the read
  logic rSel; // Read hits a selected sector
  logic ersRun; // Erase owns its bank
  logic unl1; // First unlock cycle
  logic unl2; // Second unlock cycle
  logic winEnd; // Window has run out
  logic ersEnd; // Erase phase length reached
  logic prgEnd; // Program length reached
  logic awHave; // Write address held
  logic wHave; // Write data held
  logic [7:0] awA;
  logic [31:0] wD;
  logic [3:0] wS;

  ////////////////////////////////////////////////////////////////////////
  // Decode of write and read cycles
  assign wr = weN & ~weNq;
  assign wSecBit = 16'h0001 << wAddr[fes_pkg::SEC_LSB +: fes_pkg::S_W];
  assign wBank = wAddr[fes_pkg::BANK_BIT];
  assign rBank = rdAddr[fes_pkg::BANK_BIT];
  assign rSel = sectorMask[rdAddr[fes_pkg::SEC_LSB +: fes_pkg::S_W]];
  assign unl1 = wAddr[11:0] == fes_pkg::UNL_A1 && wData == fes_pkg::C_UNL1;
  assign unl2 = wAddr[11:0] == fes_pkg::UNL_A2 && wData == fes_pkg::C_UNL2;
  assign ersRun = st == fes_pkg::S_WIN || st == fes_pkg::S_PREP ||
                  st == fes_pkg::S_ERASE;
  assign winEnd = tmr == 16'(WIN_CYC - 1);
  assign ersEnd = {1'b0, tmr} + 17'h0_0001 >= {1'b0, ctrl[15:0]};
  assign prgEnd = {1'b0, prgTmr} + 17'h0_0001 >= {1'b0, ctrl[31:16]};
  assign preprogOn = st == fes_pkg::S_PREP;
  assign eraseOn = st == fes_pkg::S_ERASE;
  assign progOn = st == fes_pkg::S_PROG;

  // Write strobe history
  always_ff @(posedge clk) begin
    if (srst) begin
      weNq <= 1'b1;
    end else begin
      weNq <= weN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  // reset aborts erase
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= fes_pkg::S_IDLE;
      eSusp <= 1'b0;
      pSusp <= 1'b0;
      bypass <= 1'b0;
      ersPhase <= 1'b0;
      ersBank <= 1'b0;
      sectorMask <= '0;
      tmr <= 16'h0000;
      prgTmr <= 16'h0000;
      progAddr <= '0;
      progData <= '0;
    end else begin
      case (st)
        // Read mode, possibly with suspends pending
        fes_pkg::S_IDLE: begin
          if (wr) begin
            if (pSusp) begin
              if (wData == fes_pkg::C_RES) begin
                pSusp <= 1'b0;
                st <= fes_pkg::S_PROG;
              end else if (unl1) begin
                st <= fes_pkg::S_CY1;
              end
            end else if (eSusp && wData == fes_pkg::C_RES &&
                         wBank == ersBank) begin
              eSusp <= 1'b0;
              st <= ersPhase ? fes_pkg::S_ERASE : fes_pkg::S_PREP;
            end else if (unl1) begin
              st <= fes_pkg::S_CY1;
            end else if (bypass && !eSusp &&
                         wData == fes_pkg::C_SETUP) begin
              st <= fes_pkg::S_SETUP;
            end else if (bypass && wData == fes_pkg::C_PGM) begin
              st <= fes_pkg::S_PSET;
            end else if (bypass && wData == fes_pkg::C_ASEL) begin
              st <= fes_pkg::S_BYX;
            end
          end
        end
        // Second unlock cycle expected
        fes_pkg::S_CY1: begin
          if (wr) begin
            st <= unl2 ? fes_pkg::S_CY2 : fes_pkg::S_IDLE;
          end
        end
        // Command after the unlock pair
        fes_pkg::S_CY2: begin
          if (wr) begin
            st <= fes_pkg::S_IDLE;
            if (wData == fes_pkg::C_SETUP && !eSusp && !pSusp) begin
              st <= fes_pkg::S_SETUP;
            end else if (wData == fes_pkg::C_PGM && !pSusp) begin
              st <= fes_pkg::S_PSET;
            end else if (wData == fes_pkg::C_ASEL) begin
              st <= fes_pkg::S_ASEL;
            end else if (wData == fes_pkg::C_BYP && !eSusp && !pSusp) begin
              bypass <= 1'b1;
            end
          end
        end
        // Erase set-up seen, unlock pair follows
        fes_pkg::S_SETUP: begin
          if (wr) begin
            st <= unl1 ? fes_pkg::S_CY4 : fes_pkg::S_IDLE;
          end
        end
        fes_pkg::S_CY4: begin
          if (wr) begin
            st <= unl2 ? fes_pkg::S_CY5 : fes_pkg::S_IDLE;
          end
        end
        // Final write carries the sector
        fes_pkg::S_CY5: begin
          if (wr) begin
            st <= fes_pkg::S_IDLE;
            if (wData == fes_pkg::C_ERS) begin
              st <= fes_pkg::S_WIN;
              sectorMask <= wSecBit;
              ersBank <= wBank;
              ersPhase <= 1'b0;
              tmr <= 16'h0000;
            end
          end
        end
        // Acceptance window for further sectors
        fes_pkg::S_WIN: begin
          if (wr) begin
            if (wData == fes_pkg::C_ERS) begin
              sectorMask <= sectorMask | wSecBit;
              tmr <= 16'h0000;
            end else if (wData == fes_pkg::C_SUSP && wBank == ersBank) begin
              eSusp <= 1'b1;
              ersPhase <= 1'b0;
              tmr <= 16'h0000;
              st <= fes_pkg::S_IDLE;
            end else begin
              sectorMask <= '0;
              st <= fes_pkg::S_IDLE;
            end
          end else if (winEnd) begin
            tmr <= 16'h0000;
            st <= fes_pkg::S_PREP;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        fes_pkg::S_PREP, fes_pkg::S_ERASE: begin
          if (wr && wData == fes_pkg::C_SUSP && wBank == ersBank) begin
            eSusp <= 1'b1;
            ersPhase <= st == fes_pkg::S_ERASE;
            st <= fes_pkg::S_IDLE;
          end else if (ersEnd) begin
            tmr <= 16'h0000;
            if (st == fes_pkg::S_PREP) begin
              st <= fes_pkg::S_ERASE;
            end else begin
              sectorMask <= '0;
              ersBank <= 1'b0;
              st <= fes_pkg::S_IDLE;
            end
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        // Program address and data cycle
        fes_pkg::S_PSET: begin
          if (wr) begin
            if (eSusp && sectorMask[wAddr[fes_pkg::SEC_LSB +: fes_pkg::S_W]])
            begin
              st <= fes_pkg::S_IDLE;
            end else begin
              progAddr <= wAddr;
              progData <= wData;
              prgTmr <= 16'h0000;
              st <= fes_pkg::S_PROG;
            end
          end
        end
        // Internal program
        fes_pkg::S_PROG: begin
          if (wr && wData == fes_pkg::C_SUSP) begin
            pSusp <= 1'b1;
            st <= fes_pkg::S_IDLE;
          end else if (prgEnd) begin
            st <= fes_pkg::S_IDLE;
          end else begin
            prgTmr <= prgTmr + 16'h0001;
          end
        end
        // Identification readout
        fes_pkg::S_ASEL: begin
          if (wr && wData == fes_pkg::C_EXIT) begin
            st <= fes_pkg::S_IDLE;
          end
        end
        // Bypass exit second cycle
        fes_pkg::S_BYX: begin
          if (wr) begin
            bypass <= wData == fes_pkg::C_BYX ? 1'b0 : bypass;
            st <= fes_pkg::S_IDLE;
          end
        end
        default: begin
          st <= fes_pkg::S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data path
  // status versus array data
  always_comb begin
    next_rdData = arrayData;
    if (st == fes_pkg::S_ASEL) begin
      next_rdData = rdAddr[0] ? fes_pkg::DEV_ID : fes_pkg::MFG_ID;
    end else if (st == fes_pkg::S_PROG &&
                 rBank == progAddr[fes_pkg::BANK_BIT]) begin
      next_rdData = 8'h00;
      next_rdData[fes_pkg::POLL_BIT] = ~progData[7];
      next_rdData[fes_pkg::TGL_BIT] = tgl;
    end else if (ersRun && rBank == ersBank) begin
      next_rdData = 8'h00;
      next_rdData[fes_pkg::TGL_BIT] = tgl;
      next_rdData[fes_pkg::WIN_BIT] = st != fes_pkg::S_WIN;
      next_rdData[fes_pkg::STGL_BIT] = rSel & sTgl;
    end else if (eSusp && rSel) begin
      next_rdData = 8'h00;
      next_rdData[fes_pkg::POLL_BIT] = 1'b1;
      next_rdData[fes_pkg::STGL_BIT] = sTgl;
    end
  end

  // Registered read data and toggle bits
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData <= 8'h00;
      tgl <= 1'b0;
      sTgl <= 1'b0;
    end else if (rdEn) begin
      rdData <= next_rdData;
      tgl <= tgl ^ ((ersRun && rBank == ersBank) ||
                    (st == fes_pkg::S_PROG &&
                     rBank == progAddr[fes_pkg::BANK_BIT]));
      sTgl <= sTgl ^ (rSel && (ersRun || eSusp));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: erase and program lengths
  assign s_axi_awready = ~awHave;
  assign s_axi_wready = ~wHave;

  always_ff @(posedge clk) begin
    if (srst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awA <= 8'h00;
      wD <= 32'h0000_0000;
      wS <= 4'h0;
      ctrl <= fes_pkg::CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fes_pkg::RESP_OK;
    end else begin
      if (s_axi_awvalid && !awHave) begin
        awHave <= 1'b1;
        awA <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave) begin
        wHave <= 1'b1;
        wD <= s_axi_wdata;
        wS <= s_axi_wstrb;
      end
      // Both halves present: commit and answer
      if (awHave && wHave && !s_axi_bvalid) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= fes_pkg::RESP_OK;
        if (awA == fes_pkg::CTRL_OFF) begin
          for (int i = 0; i < 4; i++) begin
            if (wS[i]) begin
              ctrl[i*8 +: 8] <= wD[i*8 +: 8];
            end
          end
        end else if (awA != fes_pkg::STAT_OFF) begin
          s_axi_bresp <= fes_pkg::RESP_ERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fes_pkg::RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fes_pkg::RESP_OK;
      if (s_axi_araddr == fes_pkg::CTRL_OFF) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == fes_pkg::STAT_OFF) begin
        s_axi_rdata <= {sectorMask, bypass, pSusp, eSusp, st};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= fes_pkg::RESP_ERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  win_start_a: assert property (
    st == fes_pkg::S_CY5 && wr && wData == fes_pkg::C_ERS
    |=> st == fes_pkg::S_WIN && tmr == 16'h0000)
    else $error("window did not open on final write");

  win_len_a: assert property (
    st == fes_pkg::S_PREP && $past(st) == fes_pkg::S_WIN
    |-> $past(tmr) == 16'(WIN_CYC - 1))
    else $error("window closed early");

  win_abort_a: assert property (
    st == fes_pkg::S_WIN && wr && wData != fes_pkg::C_ERS &&
    wData != fes_pkg::C_SUSP
    |=> st == fes_pkg::S_IDLE && sectorMask == '0)
    else $error("stray write did not abort window");

  flag_win_a: assert property (
    st == fes_pkg::S_WIN && rdEn && rBank == ersBank
    |=> !rdData[fes_pkg::WIN_BIT])
    else $error("window flag high in window");

  // Covers preprogram as well: the window is over in both phases
  flag_run_a: assert property (
    (st == fes_pkg::S_PREP || st == fes_pkg::S_ERASE) && rdEn &&
    rBank == ersBank
    |=> rdData[fes_pkg::WIN_BIT] && !rdData[fes_pkg::POLL_BIT])
    else $error("erase status wrong");

  // A resume may enter erase only if preprogram had already finished
  prep_first_a: assert property (
    st == fes_pkg::S_ERASE && $past(st) != fes_pkg::S_ERASE
    |-> $past(st) == fes_pkg::S_PREP ||
        ($past(st) == fes_pkg::S_IDLE && $past(ersPhase)))
    else $error("erase started without preprogram");

  ers_done_a: assert property (
    $past(st) == fes_pkg::S_ERASE && st == fes_pkg::S_IDLE && !eSusp
    |-> sectorMask == '0)
    else $error("sectors still latched after erase");

  // Phase end in the same cycle legally moves preprogram on to erase or clears the mask after erase, so skip it
  ers_ignore_a: assert property (
    (st == fes_pkg::S_PREP || st == fes_pkg::S_ERASE) && wr && !ersEnd &&
    !(wData == fes_pkg::C_SUSP && wBank == ersBank)
    |=> !eSusp && st == $past(st) && $stable(sectorMask))
    else $error("command taken during erase");

  susp_fast_a: assert property (
    ersRun && wr && wData == fes_pkg::C_SUSP && wBank == ersBank
    |=> eSusp && st == fes_pkg::S_IDLE)
    else $error("erase suspend not immediate");

  psusp_a: assert property (
    st == fes_pkg::S_PROG && wr && wData == fes_pkg::C_SUSP
    |=> pSusp && !progOn)
    else $error("program suspend missed");

  presume_a: assert property (
    st == fes_pkg::S_IDLE && pSusp && wr && wData == fes_pkg::C_RES
    |=> st == fes_pkg::S_PROG && !pSusp)
    else $error("program resume missed");

endmodule
`default_nettype wire

// ---- dv/fes_host.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Host model: drives flash write and read cycles
module fes_host (
  // Clock
  input wire logic clk,
  // Flash write cycle
  output logic weN,
  output logic [15:0] wAddr,
  output logic [7:0] wData,
  // Flash read cycle and array contents
  output logic rdEn,
  output logic [15:0] rdAddr,
  output logic [7:0] arrayData
);
  // Array contents vary with the read address
  assign arrayData = rdAddr[15:8] ^ rdAddr[7:0] ^ 8'hC5;
  // Idle bus at time zero
  initial begin
    weN = 1'h1;
    wAddr = 16'h0000;
    wData = 8'h00;
    rdEn = 1'h0;
    rdAddr = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // ordered, tight writes
  // Strobe low two cycles; taken on its rise, then bus let go
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    weN <= 1'h0;
    wAddr <= a;
    wData <= d;
    repeat (2) @(posedge clk);
    weN <= 1'h1;
    @(posedge clk);
    // Released bus shows the inverse, never the stale value
    wAddr <= ~a;
    wData <= ~d;
    @(posedge clk);
  endtask
  // One-cycle read strobe; data lands a cycle later
  task automatic rd(input logic [15:0] a);
    rdEn <= 1'h1;
    rdAddr <= a;
    @(posedge clk);
    rdEn <= 1'h0;
    rdAddr <= ~a;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/flash_erase_suspend_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_erase_suspend_sequencer_bench;
  // Clock, reset, counters
  logic clk;
  logic srst;
  int errors;
  int n_compared;
  // Flash side
  logic weN, rdEn, preprogOn, eraseOn, progOn;
  logic [15:0] wAddr, rdAddr, sectorMask, progAddr;
  logic [7:0] wData, arrayData, rdData, progData;
  // Register bus
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  // Row: write address, data, status mask, status expected
  typedef struct packed {
    logic [15:0] a;
    logic [7:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } fes_row_t;
  fes_row_t rows [7];
  ////////////////////////////////////////////////////////////
  // Short window keeps the run brief
  fes_sequencer #(.WIN_CYC(20)) DUT (
    .clk, .srst, .weN, .wAddr, .wData, .rdEn, .rdAddr, .arrayData,
    .rdData, .preprogOn, .eraseOn, .progOn, .sectorMask, .progAddr,
    .progData, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  fes_host host (.clk, .weN, .wAddr, .wData, .rdEn, .rdAddr, .arrayData);
  ////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
  ////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Register writes: both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, er});
    @(posedge clk);
  endtask
  // Register reads, masked compare of data and response
  task automatic axr(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata & m, e);
    chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, er});
    @(posedge clk);
  endtask
  task automatic st(input logic [31:0] m, e);
    axr(fes_pkg::STAT_OFF, m, e, fes_pkg::RESP_OK);
  endtask
  // Flash read through the host model, masked compare
  task automatic fr(input logic [15:0] a, input logic [7:0] m, e);
    host.rd(a);
    chk({24'h00_0000, rdData & m}, {24'h00_0000, e});
  endtask
  function automatic logic [7:0] ad(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'hC5;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.wr(a, d);
  endtask
  // Unlock pair then a command at the first unlock address
  task automatic unl(input logic [7:0] c);
    wr(16'h0555, fes_pkg::C_UNL1);
    wr(16'h02AA, fes_pkg::C_UNL2);
    wr(16'h0555, c);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'h1;
    errors = 0;
    n_compared = 0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    rows = '{
      '{16'h0555, fes_pkg::C_UNL1, 32'h0000_1FFF, 32'h0000_0002},
      '{16'h02AA, fes_pkg::C_UNL2, 32'h0000_1FFF, 32'h0000_0004},
      '{16'h0555, fes_pkg::C_SETUP, 32'h0000_1FFF, 32'h0000_0008},
      '{16'h0555, fes_pkg::C_UNL1, 32'h0000_1FFF, 32'h0000_0010},
      '{16'h02AA, fes_pkg::C_UNL2, 32'h0000_1FFF, 32'h0000_0020},
      '{16'h3000, fes_pkg::C_ERS, 32'hFFFF_FFFF, 32'h0008_0040},
      '{16'h5000, fes_pkg::C_ERS, 32'hFFFF_FFFF, 32'h0028_0040}};
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    // Reset values, unmapped place, lane-masked write
    axr(fes_pkg::CTRL_OFF, '1, fes_pkg::CTRL_RST, fes_pkg::RESP_OK);
    st(32'hFFFF_FFFF, 32'h0000_0001);
    axr(8'h10, '1, 32'h0000_0000, fes_pkg::RESP_ERR);
    axw(8'h10, 32'h0000_0000, 4'hF, fes_pkg::RESP_ERR);
    axw(fes_pkg::CTRL_OFF, 32'hFF30_FFFF, 4'h4, fes_pkg::RESP_OK);
    axr(fes_pkg::CTRL_OFF, '1, 32'h0030_0100, fes_pkg::RESP_OK);
    // Six-cycle sequence, then a second sector queued
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      st(rows[i].m, rows[i].e);
    end
    fr(16'h3000, 8'h88, 8'h00);
    fr(16'h9000, 8'hFF, ad(16'h9000));
    repeat (25) @(posedge clk);
    fr(16'h3000, 8'h88, 8'h08);
    chk({31'h0000_0000, preprogOn}, 32'h0000_0001);
    // Wrong-bank suspend and other commands ignored
    wr(16'h8000, fes_pkg::C_SUSP);
    wr(16'h0555, fes_pkg::C_UNL1);
    st(32'h0000_3FFF, 32'h0000_0080);
    wr(16'h0000, fes_pkg::C_SUSP);
    st(32'h0000_2180, 32'h0000_2000);
    fr(16'h3000, 8'h80, 8'h80);
    fr(16'h1000, 8'hFF, ad(16'h1000));
    // Program while suspended, nested suspend and readout
    unl(fes_pkg::C_PGM);
    wr(16'h1000, 8'h12);
    chk({8'h00, progAddr, progData}, 32'h0010_0012);
    fr(16'h1000, 8'h80, 8'h80);
    chk({31'h0000_0000, progOn}, 32'h0000_0001);
    wr(16'h4321, fes_pkg::C_SUSP);
    st(32'h0000_6000, 32'h0000_6000);
    unl(fes_pkg::C_ASEL);
    fr(16'h3000, 8'hFF, fes_pkg::MFG_ID);
    fr(16'h3001, 8'hFF, fes_pkg::DEV_ID);
    wr(16'h0000, fes_pkg::C_EXIT);
    st(32'h0000_4800, 32'h0000_4000);
    wr(16'h8123, fes_pkg::C_RES);
    wr(16'h8123, fes_pkg::C_RES);
    st(32'h0000_6400, 32'h0000_2400);
    repeat (60) @(posedge clk);
    st(32'h0000_6400, 32'h0000_2000);
    // Erase resume, repeat ignored, fresh suspend accepted
    wr(16'h0000, fes_pkg::C_RES);
    wr(16'h0000, fes_pkg::C_RES);
    st(32'h0000_2000, 32'h0000_0000);
    wr(16'h0000, fes_pkg::C_SUSP);
    st(32'h0000_2000, 32'h0000_2000);
    wr(16'h0000, fes_pkg::C_RES);
    // Hardware reset in mid-erase
    srst <= 1'h1;
    @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    st(32'hFFFF_FFFF, 32'h0000_0001);
    chk({30'h0000_0000, eraseOn, preprogOn}, 32'h0000_0000);
    // Foreign command inside the window
    for (int i = 0; i < 5; i++) wr(rows[i].a, rows[i].d);
    wr(16'h3000, fes_pkg::C_ERS);
    wr(16'h0000, fes_pkg::C_EXIT);
    st(32'hFFFF_FFFF, 32'h0000_0001);
    // Bypass entry, four-cycle erase, run to the end
    unl(fes_pkg::C_BYP);
    wr(16'h0555, fes_pkg::C_SETUP);
    wr(16'h0555, fes_pkg::C_UNL1);
    wr(16'h02AA, fes_pkg::C_UNL2);
    wr(16'h6000, fes_pkg::C_ERS);
    st(32'hFFFF_9FFF, 32'h0040_8040);
    chk({16'h0000, sectorMask}, 32'h0000_0040);
    // Suspend and resume in the electrical phase
    repeat (400) @(posedge clk);
    wr(16'h0000, fes_pkg::C_SUSP);
    wr(16'h0000, fes_pkg::C_RES);
    st(32'h0000_3FFF, 32'h0000_0100);
    chk({31'h0000_0000, eraseOn}, 32'h0000_0001);
    repeat (300) @(posedge clk);
    st(32'hFFFF_1FFF, 32'h0000_0001);
    fr(16'h6000, 8'hFF, ad(16'h6000));
    // Bypass exit pair
    wr(16'h0000, fes_pkg::C_ASEL);
    wr(16'h0000, fes_pkg::C_BYX);
    st(32'h0000_8000, 32'h0000_0000);
    test_done;
  end
endmodule
`default_nettype wire
